// File: usbg_pkg.sv
`default_nettype none
package usbg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] RCV_CTRL_ADDR = 8'h18;
  localparam logic [7:0] TX_CTRL_ADDR = 8'h98;
  localparam logic [7:0] BAUD_DIV_ADDR = 8'h99;
  localparam logic [7:0] RX_DATA_ADDR = 8'h1A;
  localparam logic [7:0] TX_DATA_ADDR = 8'h19;
  localparam logic [7:0] RCV_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_RST = 8'h02;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int TX_CLOCK_SOURCE_SELECT_POS = 7;
  localparam int TX_NINE_POS = 6;
  localparam int TX_EN_POS = 5;
  localparam int TX_SYNC_POS = 4;
  localparam int TX_HIGH_POS = 2;
  localparam int TX_EMPTY_POS = 1;
  localparam int TX_D9_POS = 0;
  localparam int RC_SERIAL_PORT_ENABLE_POS = 7;
  localparam int RC_NINE_POS = 6;
  localparam int RC_SINGLE_RECEIVE_ENABLE_POS = 5;
  localparam int RC_CONTINUOUS_RECEIVE_ENABLE_POS = 4;
  localparam int RC_ADDRESS_DETECT_ENABLE_POS = 3;
  localparam int RC_FRAMING_ERROR_FLAG_POS = 2;
  localparam int RC_OVERRUN_ERROR_FLAG_POS = 1;
  localparam int RC_D9_POS = 0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [5:0] TICKS_LOW = 6'h3F;
  localparam logic [5:0] TICKS_HIGH = 6'h0F;
  localparam logic [5:0] TICKS_SYNC = 6'h03;
  localparam logic [5:0] SAMPLE_A = 6'h07;
  localparam logic [5:0] SAMPLE_B = 6'h08;
  localparam logic [5:0] SAMPLE_C = 6'h09;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usbg_bus_type;
  typedef enum logic [1:0] {
    USBG_ASYNC,
    USBG_SYNC_MASTER,
    USBG_SYNC_SLAVE
  } usbg_mode_type;
  typedef enum logic [1:0] {
    USBG_IDLE,
    USBG_START,
    USBG_DATA,
    USBG_STOP
  } usbg_state_type;
endpackage : usbg_pkg
`default_nettype wire

// File: usbg_top.sv
`default_nettype none
// Behaviour
// [RULE_01] Async, sync master, sync slave modes.
// [RULE_02] Software enables port and pin directions.
// [RULE_03] Clock source picks master or slave.
// [RULE_04] Transmit nine-bit select.
// [RULE_05] Transmit enable; receive enables override sync.
// [RULE_06] Mode select bit chooses sync.
// [RULE_07] Transmit control bit three reads zero.
// [RULE_08] High-speed select only in async.
// [RULE_09] Shift empty flag read-only, resets one.
// [RULE_10] Ninth transmit bit supplied by software.
// [RULE_11] Receive nine-bit select.
// [RULE_12] Single receive cleared after one word.
// [RULE_13] Continuous receive; overrides single receive.
// [RULE_14] Address detect keeps words with bit nine.
// [RULE_15] Framing flag updates with next word.
// [RULE_16] Overrun cleared by clearing continuous receive.
// [RULE_17] Ninth received bit held for software.
// [RULE_18] Eight-bit free-running baud timer.
// [RULE_19] Bit rate divides by 64, 16, 4.
// [RULE_20] Divisor write clears the timer.
// [RULE_21] Three-sample majority on receive pin.
// [RULE_22] High-speed division advised to software.
// [RULE_23] Frame: start, eight/nine data, stop.
// [RULE_24] Least significant bit first.
// [RULE_25] Async tick is 16x or 64x.
// [RULE_26] Low stop bit sets framing flag.
module usbg_top (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire usbg_pkg::usbg_bus_type i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_rx_pin,
  input wire logic i_ck_pin,
  output logic o_tx_pin,
  output logic o_tx_oe,
  output logic o_ck_pin,
  output logic o_ck_oe,
  output logic o_dt_oe,
  output logic o_rx_valid
);
  import usbg_pkg::*;
  logic [7:0] tx_ctrl_q;
  logic [7:0] rc_ctrl_q;
  logic [7:0] div_q;
  logic [7:0] brg_q;
  logic [5:0] tick_q;
  logic [8:0] tx_hold_q;
  logic tx_full_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_busy_q;
  logic [7:0] rx_buf_q;
  logic rx_full_q;
  logic framing_error_flag_q;
  logic overrun_error_flag_q;
  logic rx9_q;
  logic [1:0] rx_sync_q;
  logic [1:0] ck_sync_q;
  logic ck_prev_q;
  logic [2:0] samp_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [5:0] rx_tick_q;
  usbg_state_type rx_state_q;
  logic [7:0] rdata_q;
  logic ck_q;
  logic sync_mode;
  logic master;
  logic brg_tick;
  logic bit_tick;
  logic [5:0] tick_max;
  logic serial_port_enable;
  logic rx_en;
  logic tx_en;
  logic [3:0] tx_len;
  logic [3:0] rx_len;
  logic rx_done;
  logic rx_stop_ok;
  logic rx_accept;
  logic rx_rd;
  logic maj;
  logic rx_bit;
  usbg_mode_type mode;
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign sync_mode = tx_ctrl_q[TX_SYNC_POS]; // RULE_06
  assign master = tx_ctrl_q[TX_CLOCK_SOURCE_SELECT_POS]; // RULE_03
  assign serial_port_enable = rc_ctrl_q[RC_SERIAL_PORT_ENABLE_POS];
  always_comb begin
    if (!sync_mode) begin
      mode = USBG_ASYNC; // RULE_01
    end else if (master) begin
      mode = USBG_SYNC_MASTER;
    end else begin
      mode = USBG_SYNC_SLAVE;
    end
  end
  assign rx_en = rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS] |
                 (mode == USBG_SYNC_MASTER && rc_ctrl_q[RC_SINGLE_RECEIVE_ENABLE_POS]); // RULE_12
  assign tx_en = tx_ctrl_q[TX_EN_POS] & !(sync_mode & rx_en) & serial_port_enable; // RULE_05
  assign tx_len = tx_ctrl_q[TX_NINE_POS] ? 4'hB : 4'hA; // RULE_04 RULE_23
  assign rx_len = rc_ctrl_q[RC_NINE_POS] ? 4'h9 : 4'h8; // RULE_11
  always_comb begin
    if (sync_mode) begin
      tick_max = TICKS_SYNC;
    end else if (tx_ctrl_q[TX_HIGH_POS]) begin
      tick_max = TICKS_HIGH; // RULE_08 RULE_25
    end else begin
      tick_max = TICKS_LOW;
    end
  end
  // ----------------------------------------
  // Baud generator
  // ----------------------------------------
  assign brg_tick = (brg_q == div_q);
  assign bit_tick = brg_tick && (tick_q >= tick_max);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || (i_bus.wr && i_bus.addr == BAUD_DIV_ADDR)) begin
      brg_q <= 8'h00; // RULE_20
    end else if (brg_tick) begin
      brg_q <= 8'h00; // RULE_18
    end else begin
      brg_q <= brg_q + 8'h01;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || (i_bus.wr && i_bus.addr == BAUD_DIV_ADDR) || bit_tick) begin
      tick_q <= 6'h00;
    end else if (brg_tick) begin
      tick_q <= tick_q + 6'h01; // RULE_19
    end
  end
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  assign rx_rd = i_bus.rd && i_bus.addr == RX_DATA_ADDR;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_ctrl_q <= TX_CTRL_RST;
      div_q <= BAUD_DIV_RST;
    end else if (i_bus.wr && i_bus.addr == TX_CTRL_ADDR) begin
      tx_ctrl_q <= {i_bus.wdata[7:4], 1'b0, i_bus.wdata[2], 1'b0, i_bus.wdata[0]}; // RULE_07
    end else if (i_bus.wr && i_bus.addr == BAUD_DIV_ADDR) begin
      div_q <= i_bus.wdata;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rc_ctrl_q <= RCV_CTRL_RST;
    end else if (i_bus.wr && i_bus.addr == RCV_CTRL_ADDR) begin
      rc_ctrl_q <= {i_bus.wdata[7:3], 3'b000};
    end else if (rx_done && mode == USBG_SYNC_MASTER && !rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS]) begin
      rc_ctrl_q[RC_SINGLE_RECEIVE_ENABLE_POS] <= 1'b0; // RULE_12 RULE_13
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
    end else if (i_bus.rd) begin
      if (i_bus.addr == TX_CTRL_ADDR) begin
        rdata_q <= {tx_ctrl_q[7:2], !tx_busy_q, tx_ctrl_q[0]}; // RULE_09
      end else if (i_bus.addr == RCV_CTRL_ADDR) begin
        rdata_q <= {rc_ctrl_q[7:3], framing_error_flag_q, overrun_error_flag_q, rx9_q}; // RULE_15 RULE_16 RULE_17
      end else if (i_bus.addr == BAUD_DIV_ADDR) begin
        rdata_q <= div_q;
      end else if (i_bus.addr == RX_DATA_ADDR) begin
        rdata_q <= rx_buf_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign o_rdata = rdata_q;
  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_hold_q <= 9'h000;
      tx_full_q <= 1'b0;
    end else if (i_bus.wr && i_bus.addr == TX_DATA_ADDR) begin
      tx_hold_q <= {tx_ctrl_q[TX_D9_POS], i_bus.wdata}; // RULE_10
      tx_full_q <= 1'b1;
    end else if (tx_full_q && !tx_busy_q && tx_en && bit_tick) begin
      tx_full_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tx_sh_q <= 11'h7FF;
      tx_cnt_q <= 4'h0;
      tx_busy_q <= 1'b0;
    end else if (!tx_busy_q) begin
      if (tx_full_q && tx_en && bit_tick) begin
        tx_busy_q <= 1'b1;
        tx_cnt_q <= sync_mode ? (tx_len - 4'h2) : tx_len;
        if (sync_mode) begin
          tx_sh_q <= {2'b11, tx_hold_q};
        end else if (tx_ctrl_q[TX_NINE_POS]) begin
          tx_sh_q <= {1'b1, tx_hold_q, 1'b0};
        end else begin
          tx_sh_q <= {2'b11, tx_hold_q[7:0], 1'b0};
        end
      end
    end else if (bit_tick) begin
      tx_sh_q <= {1'b1, tx_sh_q[10:1]}; // RULE_24
      tx_cnt_q <= tx_cnt_q - 4'h1;
      if (tx_cnt_q == 4'h1) begin
        tx_busy_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !tx_busy_q || mode != USBG_SYNC_MASTER) begin
      ck_q <= 1'b1;
    end else if (brg_tick && tick_q == 6'h01) begin
      ck_q <= 1'b0;
    end else if (bit_tick) begin
      ck_q <= 1'b1;
    end
  end
  assign o_tx_pin = sync_mode ? ck_q : tx_sh_q[0];
  assign o_tx_oe = serial_port_enable && (!sync_mode || master);
  assign o_ck_pin = ck_q;
  assign o_ck_oe = serial_port_enable && mode == USBG_SYNC_MASTER;
  assign o_dt_oe = serial_port_enable && sync_mode && tx_busy_q;
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_sync_q <= 2'b11;
      ck_sync_q <= 2'b11;
      ck_prev_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[0], i_rx_pin};
      ck_sync_q <= {ck_sync_q[0], i_ck_pin};
      ck_prev_q <= ck_sync_q[1];
    end
  end
  assign maj = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) | (samp_q[0] & samp_q[2]);
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      samp_q <= 3'b111;
    end else if (brg_tick && (rx_tick_q == SAMPLE_A || rx_tick_q == SAMPLE_B ||
                 rx_tick_q == SAMPLE_C)) begin
      samp_q <= {samp_q[1:0], rx_sync_q[1]}; // RULE_21
    end
  end
  assign rx_bit = sync_mode ? (ck_sync_q[1] & !ck_prev_q) :
                  (brg_tick && rx_tick_q == tick_max);
  assign rx_stop_ok = sync_mode ? 1'b1 : maj;
  assign rx_done = rx_state_q == USBG_STOP && (sync_mode || rx_bit);
  assign rx_accept = rx_done && !(rc_ctrl_q[RC_ADDRESS_DETECT_ENABLE_POS] && !sync_mode &&
                     rc_ctrl_q[RC_NINE_POS] && !rx_sh_q[8]); // RULE_14
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !serial_port_enable || !rx_en) begin
      rx_state_q <= USBG_IDLE;
      rx_tick_q <= 6'h00;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else begin
      if (brg_tick) begin
        rx_tick_q <= (rx_tick_q == tick_max) ? 6'h00 : rx_tick_q + 6'h01;
      end
      case (rx_state_q)
        USBG_IDLE: begin
          if (sync_mode) begin
            rx_state_q <= USBG_DATA;
            rx_cnt_q <= rx_len;
          end else if (!rx_sync_q[1]) begin
            rx_state_q <= USBG_START;
            rx_tick_q <= 6'h00;
          end
        end
        USBG_START: begin
          if (rx_bit) begin
            rx_state_q <= maj ? USBG_IDLE : USBG_DATA;
            rx_cnt_q <= rx_len;
          end
        end
        USBG_DATA: begin
          if (rx_bit) begin
            rx_sh_q <= {sync_mode ? rx_sync_q[1] : maj, rx_sh_q[8:1]}; // RULE_24
            rx_cnt_q <= rx_cnt_q - 4'h1;
            if (rx_cnt_q == 4'h1) begin
              rx_state_q <= USBG_STOP;
            end
          end
        end
        default: begin
          if (rx_bit || sync_mode) begin
            rx_state_q <= USBG_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      rx9_q <= 1'b0;
    end else if (rx_accept && (!rx_full_q || rx_rd)) begin
      rx_buf_q <= rc_ctrl_q[RC_NINE_POS] ? rx_sh_q[7:0] : rx_sh_q[8:1];
      rx9_q <= rx_sh_q[8]; // RULE_17
      framing_error_flag_q <= !rx_stop_ok; // RULE_15 RULE_26
      rx_full_q <= 1'b1;
    end else if (rx_rd) begin
      rx_full_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS]) begin
      overrun_error_flag_q <= 1'b0; // RULE_16
    end else if (rx_accept && rx_full_q && !rx_rd) begin
      overrun_error_flag_q <= 1'b1;
    end
  end
  assign o_rx_valid = rx_full_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  div_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_bus.wr && i_bus.addr == BAUD_DIV_ADDR) |=> brg_q == 8'h00) // RULE_20
    else $error("baud timer not cleared");
  brg_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    brg_tick && !(i_bus.wr && i_bus.addr == BAUD_DIV_ADDR) |=> brg_q == 8'h00) // RULE_18
    else $error("baud timer did not wrap");
  bit_three_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    tx_ctrl_q[3] == 1'b0) // RULE_07
    else $error("unimplemented bit set");
  tx_override_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    sync_mode && rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS] |-> !tx_en) // RULE_05
    else $error("transmit not overridden");
  overrun_error_flag_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    $fell(rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS]) |=> !overrun_error_flag_q) // RULE_16
    else $error("overrun not cleared");
  single_receive_enable_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    rx_done && mode == USBG_SYNC_MASTER && !rc_ctrl_q[RC_CONTINUOUS_RECEIVE_ENABLE_POS] &&
    !(i_bus.wr && i_bus.addr == RCV_CTRL_ADDR) |=> !rc_ctrl_q[RC_SINGLE_RECEIVE_ENABLE_POS]) // RULE_12
    else $error("single receive not cleared");
  tick_range_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    bit_tick |=> tick_q == 6'h00) // RULE_19
    else $error("tick count not restarted");
  rx_drain_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    rx_rd && !rx_accept |=> !rx_full_q) // RULE_15
    else $error("receive buffer not drained");
  framing_error_flag_load_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    rx_accept && (!rx_full_q || rx_rd) |=> framing_error_flag_q == !$past(rx_stop_ok)) // RULE_26
    else $error("framing flag not loaded");
  shift_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    tx_full_q && !tx_busy_q && tx_en && bit_tick |=> tx_busy_q) // RULE_09
    else $error("shift register not loaded");
  ck_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    o_ck_oe == (serial_port_enable && sync_mode && master)) // RULE_03
    else $error("clock drive wrong");
  rx_off_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    !rx_en |=> rx_state_q == USBG_IDLE) // RULE_13
    else $error("receiver runs while disabled");
  addr_filter_a: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    rx_done && !sync_mode && rc_ctrl_q[RC_ADDRESS_DETECT_ENABLE_POS] && rc_ctrl_q[RC_NINE_POS] &&
    !rx_sh_q[8] && !rx_full_q |=> !rx_full_q) // RULE_14
    else $error("data word loaded in address mode");
endmodule : usbg_top
`default_nettype wire

// File: usbg_term_model.sv
`default_nettype none
module usbg_term_model (
  input wire logic i_tx_pin,
  output var logic o_rx_line,
  output var logic o_ck_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Serial terminal and synchronous peer
  // ----------------------------------------
  initial begin
    o_rx_line = 1'b1;
    o_ck_line = 1'b1;
  end
  // Sends one async frame with a short glitch in each data bit.
  task automatic send(input logic [8:0] w, input int nb, input logic stp, input int bt);
    o_rx_line = 1'b0;
    #(bt);
    for (int i = 0; i < nb; i++) begin
      o_rx_line = w[i];
      #(bt / 2 - 20);
      o_rx_line = ~w[i];
      #40;
      o_rx_line = w[i];
      #(bt / 2 - 20);
    end
    o_rx_line = stp;
    #(bt);
    o_rx_line = 1'b1;
    #(bt);
  endtask : send
  // Clocks one byte in as a synchronous peer; the clock stands high between frames.
  task automatic ssend(input logic [7:0] w);
    for (int i = 0; i < 8; i++) begin
      o_ck_line = 1'b0;
      o_rx_line = w[i];
      #100;
      o_ck_line = 1'b1;
      #100;
    end
    #100;
    o_rx_line = ~w[7];
  endtask : ssend
  // Captures one async frame from the transmit pin at mid-bit.
  task automatic capture(input int nb, input int bt, output logic [8:0] w, output logic stp,
                         output bit ok);
    int t;
    w = 9'h000;
    for (t = 0; t < 100000 && i_tx_pin !== 1'b0; t++) #1;
    ok = (t < 100000);
    #(bt / 2);
    for (int i = 0; i < nb; i++) begin
      #(bt);
      w[i] = i_tx_pin;
    end
    #(bt);
    stp = i_tx_pin;
  endtask : capture
endmodule : usbg_term_model
`default_nettype wire

// File: usart_control_baud_gen_bench.sv
`default_nettype none
module usart_control_baud_gen_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import usbg_pkg::*;
  logic clk, srst, tx_pin, tx_oe, ck_oe, dt_oe, rx_valid, rx_line, ck_line;
  logic [7:0] rdata;
  usbg_bus_type bus;
  int errors;
  int n_compared;
  logic [23:0] rows [7] = '{24'h98_6D67, 24'h98_0002, 24'h99_A5A5, 24'h99_FFFF,
                            24'h18_EEE8, 24'h18_0000, 24'h55_FF00};
  logic [23:0] rates [2] = '{24'h24_0230, 24'h20_0040};
  usbg_top usbg_top_i (.i_clk_sys(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata),
    .i_rx_pin(rx_line), .i_ck_pin(ck_line), .o_tx_pin(tx_pin), .o_tx_oe(tx_oe),
    .o_ck_pin(), .o_ck_oe(ck_oe), .o_dt_oe(dt_oe), .o_rx_valid(rx_valid));
  usbg_term_model usbg_term_model_i (.i_tx_pin(tx_pin), .o_rx_line(rx_line),
    .o_ck_line(ck_line));
  // ----------------------------------------
  // Clock and tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string what);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata & m, e, what);
  endtask : rchk
  task automatic wait_valid;
    int t;
    for (t = 0; t < 2000 && rx_valid !== 1'b1; t++) @(posedge clk);
    if (t == 2000) begin
      errors++;
      $display("ERROR %0t: no received word", $time);
      close_out();
    end
  endtask : wait_valid
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [8:0] w;
    logic s;
    bit ok;
    int t, n;
    bus = '0;
    srst = 1'b1;
    errors = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rchk(RCV_CTRL_ADDR, 8'hFF, RCV_CTRL_RST, "rc reset");
    rchk(TX_CTRL_ADDR, 8'hFF, TX_CTRL_RST, "tx reset");
    rchk(BAUD_DIV_ADDR, 8'hFF, BAUD_DIV_RST, "div reset");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], 8'hFF, rows[i][7:0], "register row");
    end
    wr(BAUD_DIV_ADDR, 8'h01);
    wr(RCV_CTRL_ADDR, 8'h80);
    wr(TX_CTRL_ADDR, 8'h65);
    fork
      usbg_term_model_i.capture(9, 800, w, s, ok);
      begin
        wr(TX_DATA_ADDR, 8'hA7);
        repeat (40) @(posedge clk);
        rchk(TX_CTRL_ADDR, 8'hFF, 8'h65, "shift full");
        chk({7'h00, tx_oe}, 8'h01, "tx drive");
      end
    join
    chk({7'h00, ok}, 8'h01, "tx start");
    chk(w[7:0], 8'hA7, "tx data");
    chk({6'h00, w[8], s}, 8'h03, "ninth and stop");
    #1000;
    rchk(TX_CTRL_ADDR, 8'hFF, 8'h67, "shift empty");
    foreach (rates[i]) begin
      wr(BAUD_DIV_ADDR, rates[i][15:8]);
      wr(TX_CTRL_ADDR, rates[i][23:16]);
      wr(TX_DATA_ADDR, 8'h01);
      for (t = 0; t < 2000 && tx_pin !== 1'b0; t++) @(posedge clk);
      for (n = 0; n < 1000 && tx_pin === 1'b0; n++) @(posedge clk);
      chk(n[7:0], rates[i][7:0], "bit length");
      repeat (700) @(posedge clk);
    end
    wr(BAUD_DIV_ADDR, 8'h01);
    wr(TX_CTRL_ADDR, 8'h04);
    wr(RCV_CTRL_ADDR, 8'h90);
    usbg_term_model_i.send(9'h03C, 8, 1'b1, 800);
    wait_valid();
    rchk(RCV_CTRL_ADDR, 8'hFE, 8'h90, "rx status");
    rchk(RX_DATA_ADDR, 8'hFF, 8'h3C, "rx data");
    repeat (2) @(posedge clk);
    chk({7'h00, rx_valid}, 8'h00, "rx drained");
    usbg_term_model_i.send(9'h05A, 8, 1'b0, 800);
    wait_valid();
    rchk(RCV_CTRL_ADDR, 8'hFE, 8'h94, "framing");
    rchk(RX_DATA_ADDR, 8'hFF, 8'h5A, "framing data");
    usbg_term_model_i.send(9'h011, 8, 1'b1, 800);
    usbg_term_model_i.send(9'h022, 8, 1'b1, 800);
    rchk(RCV_CTRL_ADDR, 8'hFE, 8'h92, "overrun");
    wr(RCV_CTRL_ADDR, 8'h80);
    rchk(RCV_CTRL_ADDR, 8'hFE, 8'h80, "overrun clear");
    rchk(RX_DATA_ADDR, 8'hFF, 8'h11, "kept word");
    wr(RCV_CTRL_ADDR, 8'hD8);
    usbg_term_model_i.send(9'h055, 9, 1'b1, 800);
    chk({7'h00, rx_valid}, 8'h00, "address skip");
    usbg_term_model_i.send(9'h1AA, 9, 1'b1, 800);
    wait_valid();
    rchk(RCV_CTRL_ADDR, 8'hFF, 8'hD9, "address word");
    rchk(RX_DATA_ADDR, 8'hFF, 8'hAA, "address data");
    wr(RCV_CTRL_ADDR, 8'h90);
    wr(TX_CTRL_ADDR, 8'h10);
    chk({6'h00, ck_oe, dt_oe}, 8'h00, "slave drive");
    usbg_term_model_i.ssend(8'hC3);
    wait_valid();
    rchk(RX_DATA_ADDR, 8'hFF, 8'hC3, "sync data");
    wr(TX_CTRL_ADDR, 8'h90);
    repeat (2) @(posedge clk);
    chk({7'h00, ck_oe}, 8'h01, "master clock drive");
    wr(RCV_CTRL_ADDR, 8'hA0);
    usbg_term_model_i.ssend(8'h5C);
    wait_valid();
    rchk(RCV_CTRL_ADDR, 8'hF8, 8'h80, "single receive clear");
    rchk(RX_DATA_ADDR, 8'hFF, 8'h5C, "single receive data");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rchk(TX_CTRL_ADDR, 8'hFF, 8'h02, "tx after reset");
    rchk(RCV_CTRL_ADDR, 8'hFF, 8'h00, "rc after reset");
    close_out();
  end
endmodule : usart_control_baud_gen_bench
`default_nettype wire
